// >>> core/lmv_regs.v
// Monitor, output-voltage and battery-droop register bank.
`timescale 1ns/1ps
`include "lmv_regs_map.vh"
//
// Operation
// - Monitor enable bit gates temperature monitoring.
// - Overtemp flag sets below hot threshold.
// - Overtemp flag clears only on zero write.
// - Warning flag sets below warning threshold.
// - Reading the register clears warning flag.
// - Warning flag ignores host writes.
// - Headroom bit updates once at strobe end.
// - Headroom reads one when headroom sufficient.
// - Voltage code reads return calibration result.
// - Voltage code writes set target voltage.
// - Droop register holds enable, threshold, revision.
// - Revision read-only, droop fields read-write.
// - Overtemp latched forces shutdown.
// - Monitor register sits at offset six.
module lmv_regs #(
    parameter [2:0] REVISION = `LMV_REV_DEFAULT
) (
    ref_clk,
    rst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    hot_cmp,
    warn_cmp,
    strobe_active,
    headroom_good,
    cal_done,
    cal_code,
    ts_monitor_en,
    shutdown,
    vout_target,
    droop_monitor_enable,
    droop_threshold_sel
);
    input  wire       ref_clk;
    input  wire       rst;
    input  wire [7:0] reg_addr;
    input  wire [7:0] reg_wdata;
    input  wire       reg_wr;
    input  wire       reg_rd;
    output reg  [7:0] reg_rdata;
    input  wire       hot_cmp;
    input  wire       warn_cmp;
    input  wire       strobe_active;
    input  wire       headroom_good;
    input  wire       cal_done;
    input  wire [3:0] cal_code;
    output reg        ts_monitor_en;
    output reg        shutdown;
    output reg  [3:0] vout_target;
    output reg        droop_monitor_enable;
    output reg  [2:0] droop_threshold_sel;

    wire       hot_s;
    wire       warn_s;
    reg        hot_q;
    reg        warn_q;
    reg        hdr_q;
    reg        strb_q;
    reg  [3:0] ov_rd_q;
    reg        hot_d;
    reg        warn_d;
    reg  [7:0] rdata_d;

    // Address decode is a plain compare on the byte address.
    // Any other address reads as zero and ignores writes.
    // This keeps an unmapped access from disturbing a flag.
    wire sel_mon   = (reg_addr == `LMV_ADDR_MON);
    wire sel_droop = (reg_addr == `LMV_ADDR_DROOP);
    wire wr_mon    = reg_wr && sel_mon;
    wire rd_mon    = reg_rd && sel_mon;
    // Detection counts only while monitoring is on, so a disabled sensor raises nothing.
    wire hot_det   = hot_s && ts_monitor_en;
    wire warn_det  = warn_s && ts_monitor_en;
    wire strb_end  = strb_q && !strobe_active;

    lmv_sync u_hot_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (hot_cmp),
        .sync_out (hot_s)
    );

    lmv_sync u_warn_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (warn_cmp),
        .sync_out (warn_s)
    );

    always @* begin
        hot_d = hot_q;
        if (wr_mon && !reg_wdata[`LMV_BIT_HOT]) begin
            hot_d = 1'b0;
        end
        if (hot_det) begin
            hot_d = 1'b1;
        end
        warn_d = warn_q;
        if (rd_mon) begin
            warn_d = 1'b0;
        end
        if (warn_det) begin
            warn_d = 1'b1;
        end
    end

    always @* begin
        rdata_d = 8'h00;
        if (sel_mon) begin
            rdata_d[`LMV_BIT_TS_EN] = ts_monitor_en;
            rdata_d[`LMV_BIT_HOT]   = hot_q;
            rdata_d[`LMV_BIT_WARN]  = warn_q;
            rdata_d[`LMV_BIT_HDR]   = hdr_q;
            rdata_d[`LMV_OV_MSB:`LMV_OV_LSB] = ov_rd_q;
        end else if (sel_droop) begin
            rdata_d[`LMV_BIT_DROOP_EN] = droop_monitor_enable;
            rdata_d[`LMV_DROOP_MSB:`LMV_DROOP_LSB] = droop_threshold_sel;
            rdata_d[`LMV_REV_MSB:`LMV_REV_LSB] = REVISION;
        end
    end

    // Each field group has its own process so that its update rule stands alone.
    // Both flags share one process because shutdown is derived from the hot flag.
    always @(posedge ref_clk) begin
        if (rst) begin
            hot_q    <= 1'b0;
            warn_q   <= 1'b0;
            shutdown <= 1'b0;
        end else begin
            hot_q    <= hot_d;
            warn_q   <= warn_d;
            // Shutdown follows the next flag value, so the LED is cut in the cycle the flag sets.
            shutdown <= hot_d;
        end
    end

    // Headroom is captured on the first low cycle after a strobe, ahead of the ramp-down.
    // Between strobes the bit holds, so a late read still sees the last strobe's result.
    always @(posedge ref_clk) begin
        if (rst) begin
            strb_q <= 1'b0;
            hdr_q  <= 1'b0;
        end else begin
            strb_q <= strobe_active;
            if (strb_end) begin
                hdr_q <= headroom_good;
            end
        end
    end

    // Monitor enable and target code are the writable fields of the monitor register.
    always @(posedge ref_clk) begin
        if (rst) begin
            ts_monitor_en <= `LMV_RST_TS_EN;
            vout_target   <= `LMV_RST_OV;
        end else if (wr_mon) begin
            ts_monitor_en <= reg_wdata[`LMV_BIT_TS_EN];
            vout_target   <= reg_wdata[`LMV_OV_MSB:`LMV_OV_LSB];
        end
    end

    // Software writes do not touch the readback; only calibration does.
    // A host therefore cannot read back the target it wrote, which is intended.
    always @(posedge ref_clk) begin
        if (rst) begin
            ov_rd_q <= `LMV_RST_OV;
        end else if (cal_done) begin
            ov_rd_q <= cal_code;
        end
    end

    // The revision field has no storage, so only these two fields follow writes.
    always @(posedge ref_clk) begin
        if (rst) begin
            droop_monitor_enable <= `LMV_RST_DROOP_EN;
            droop_threshold_sel  <= `LMV_RST_DROOP_SEL;
        end else if (reg_wr && sel_droop) begin
            droop_monitor_enable <= reg_wdata[`LMV_BIT_DROOP_EN];
            droop_threshold_sel  <= reg_wdata[`LMV_DROOP_MSB:`LMV_DROOP_LSB];
        end
    end

    // Read data is registered, so it shows the flags as they stood before a clearing read.
    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end
endmodule

// >>> core/lmv_regs_map.vh
// Register offsets, field positions, reset values and millivolt constants for the monitor bank.
`ifndef LMV_REGS_MAP_VH
`define LMV_REGS_MAP_VH
`define LMV_ADDR_MON        8'h06
`define LMV_ADDR_DROOP      8'h07
`define LMV_BIT_TS_EN       7
`define LMV_BIT_HOT         6
`define LMV_BIT_WARN        5
`define LMV_BIT_HDR         4
`define LMV_OV_MSB          3
`define LMV_OV_LSB          0
`define LMV_BIT_DROOP_EN    7
`define LMV_DROOP_MSB       6
`define LMV_DROOP_LSB       4
`define LMV_REV_MSB         2
`define LMV_REV_LSB         0
`define LMV_RST_OV          4'h9
`define LMV_RST_DROOP_SEL   3'h4
`define LMV_RST_TS_EN       1'h0
`define LMV_RST_DROOP_EN    1'h0
`define LMV_REV_DEFAULT     3'h6
`define LMV_OV_MIN_MV       3825
`define LMV_OV_STEP_MV      125
`define LMV_HOT_MV          345
`define LMV_WARN_MV         1050
`endif

// >>> core/lmv_sync.v
// Two-flop synchroniser for a single level.
`timescale 1ns/1ps
module lmv_sync (
    ref_clk,
    rst,
    async_in,
    sync_out
);
    input  wire ref_clk;
    input  wire rst;
    input  wire async_in;
    output wire sync_out;

    reg meta_q;
    reg sync_q;

    // The first stage feeds only the second stage.
    always @(posedge ref_clk) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// >>> verif/lmv_ana.sv
// Analog front model: thermistor comparators for warm and hot.
`timescale 1ns/1ps
module lmv_ana(input wire [1:0] temp,output wire hot_cmp,output wire warn_cmp);
// Levels settle off the clock edge, so the synchroniser sees a true async input.
assign #7 warn_cmp = temp!=2'h0;
assign #7 hot_cmp = temp==2'h2;
endmodule

// >>> verif/lmv_regs_props.sv
// Port assertions for the monitor register bank.
`timescale 1ns/1ps
module lmv_props #(parameter [2:0] REVISION = 3'h6) (
input wire ref_clk,rst,reg_wr,reg_rd,hot_cmp,warn_cmp,strobe_active,headroom_good,
input wire shutdown,ts_monitor_en,
input wire [7:0] reg_addr,reg_wdata,reg_rdata);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
wire clr = reg_wr && reg_addr==8'h06 && !reg_wdata[6];
en_gate_a: assert property (!ts_monitor_en && !shutdown |=> !shutdown)
else $error("set while off");
hot_set_a: assert property (hot_cmp[*4] ##0 ts_monitor_en |=> shutdown)
else $error("no shutdown");
hot_hold_a: assert property (shutdown && !clr |=> shutdown)
else $error("flag lost");
hot_clr_a: assert property (!hot_cmp[*4] ##0 clr |=> !shutdown)
else $error("flag kept");
warn_clr_a: assert property (!warn_cmp[*4] ##0 reg_rd && reg_addr==8'h06 ##1
reg_addr==8'h06 |=> !reg_rdata[5]) else $error("warn kept");
no_map_a: assert property (reg_addr>8'h07 |=> reg_rdata==8'h00)
else $error("unmapped data");
rev_ro_a: assert property (reg_addr==8'h07 |=> reg_rdata[3:0]=={1'h0,REVISION})
else $error("bad revision");
hdr_cap_a: assert property ($fell(strobe_active) ##1 reg_addr==8'h06 |=>
reg_rdata[4]==$past(headroom_good,2)) else $error("bad headroom");
endmodule
bind lmv_regs lmv_props #(.REVISION(REVISION)) u_props(.*);

// >>> verif/lmv_regs_test.sv
// Self-checking bench for the monitor register bank.
`timescale 1ns/1ps
module lmv_regs_test;
reg ref_clk=0,rst=1,reg_wr=0,reg_rd=0,strobe_active=0,headroom_good=0,cal_done=0;
reg [7:0] reg_addr=0,reg_wdata=0,r,d;
reg [3:0] cal_code=0;
reg [1:0] temp=0;
integer seed=98848,mismatches=0,compares=0,i;
wire hot_cmp,warn_cmp,ts_monitor_en,shutdown,droop_monitor_enable;
wire [7:0] reg_rdata;
wire [3:0] vout_target;
wire [2:0] droop_threshold_sel;
always #12.5 ref_clk=~ref_clk;
lmv_ana u_ana(.*);
lmv_regs u_dut(.*);
task chk(input [7:0] g,e); begin compares=compares+1;
if (g!==e) begin mismatches=mismatches+1; $display("wrong value %0t %h %h",$time,g,e); end
end endtask
task wr(input [7:0] a,b); begin @(posedge ref_clk); reg_addr<=a; reg_wdata<=b; reg_wr<=1;
@(posedge ref_clk); reg_wr<=0; end endtask
task rd(input [7:0] a); begin @(posedge ref_clk); reg_addr<=a; reg_rd<=1;
@(posedge ref_clk); reg_rd<=0; #1 r=reg_rdata; end endtask
task tick(input integer n); repeat(n) @(posedge ref_clk); endtask
task close_out; begin $display("mismatches %0d compares %0d",mismatches,compares);
if (mismatches==0 && compares>0) $display("verification passed");
else $display("verification failed");
$finish; end endtask
// Revision is a fixed strap, so only the upper nibble follows writes.
function [7:0] dx(input [7:0] b); dx={b[7:4],1'h0,3'h6}; endfunction
initial begin #100000; mismatches=mismatches+1; close_out; end
initial begin tick(2); rst<=0;
rd(8'h06); chk(r,8'h09);
rd(8'h07); chk(r,8'h46);
for (i=0;i<4;i=i+1) begin d=$random(seed); wr(8'h07,d); rd(8'h07); chk(r,dx(d));
chk({droop_monitor_enable,droop_threshold_sel},d[7:4]);
d=$random(seed)&8'h3F; wr(8'h06,d); rd(8'h06); chk(r,8'h09);
chk(vout_target,d[3:0]); end
tick(1); cal_code<=$random(seed); cal_done<=1; tick(1); cal_done<=0;
wr(8'h06,8'h80); rd(8'h06); chk(r,{4'h8,cal_code});
chk(ts_monitor_en,1);
temp<=1; tick(6); temp<=0; tick(6); rd(8'h06); chk(r,{4'hA,cal_code});
rd(8'h06); chk(r,{4'h8,cal_code});
temp<=1; tick(6); rd(8'h06); rd(8'h06); temp<=0; chk(r[5],1);
temp<=2; tick(6); temp<=0; tick(6); chk(shutdown,1);
wr(8'h06,8'hC0); rd(8'h06); chk(r,{4'hE,cal_code});
wr(8'h06,8'h80); rd(8'h06); chk(r,{4'h8,cal_code});
chk(shutdown,0);
for (i=0;i<4;i=i+1) begin d=$random(seed); tick(1); strobe_active<=1; headroom_good<=d[0];
tick(3); strobe_active<=0; tick(1); headroom_good<=~d[0];
rd(8'h06); chk(r[4],d[0]); end
d=$random(seed)|8'h08; rd(d); chk(r,8'h00);
close_out; end
endmodule
